// File: verilog/sso_pkg.sv
// Purpose: Shared constants and types for the servo status output block.
// Assumes: 100 MHz system clock, Avalon-MM register access with 32-bit data.
// Notes:   Register offsets are byte addresses of aligned words.
package sso_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0]  OFS_ROT_THR    = 8'h00;
  localparam logic [7:0]  OFS_LIN_THR    = 8'h04;
  localparam logic [7:0]  OFS_ROT_LIM    = 8'h08;
  localparam logic [7:0]  OFS_LIN_LIM    = 8'h0C;
  localparam logic [7:0]  OFS_MODE       = 8'h10;
  localparam logic [7:0]  OFS_OUT_ALLOC  = 8'h14;
  localparam logic [7:0]  OFS_OUT_POL    = 8'h18;
  localparam logic [7:0]  OFS_CTRL       = 8'h1C;
  localparam logic [7:0]  OFS_SPEED      = 8'h20;
  localparam logic [7:0]  OFS_STATUS     = 8'h24;
  // ==========================================================================
  // Reset values and ranges
  localparam logic [15:0] RST_ROT_THR    = 16'h0014;
  localparam logic [15:0] RST_LIN_THR    = 16'h0014;
  localparam logic [15:0] RST_ROT_LIM    = 16'h2710;
  localparam logic [15:0] RST_LIN_LIM    = 16'h0032;
  localparam logic [15:0] RST_MODE       = 16'h0000;
  localparam logic [15:0] RST_OUT_ALLOC  = 16'h0000;
  localparam logic [15:0] RST_OUT_POL    = 16'h0000;
  localparam logic [15:0] RST_CTRL       = 16'h0000;
  localparam logic [15:0] THR_MIN        = 16'h0001;
  localparam logic [15:0] THR_MAX        = 16'h2710;
  localparam logic [15:0] LIN_LIM_MAX    = 16'h0064;
  // Linear limit unit is 100 mm/s; speed input is in mm/s.
  localparam logic [15:0] LIN_LIM_SCALE  = 16'h0064;
  // ==========================================================================
  // Field positions
  localparam int          MODE_DIG_LSB   = 4;
  localparam logic [3:0]  MODE_VELOCITY  = 4'h0;
  localparam int          WARN_DIG_LSB   = 4;
  localparam int          CTRL_SON       = 0;
  localparam int          CTRL_CMD       = 1;
  localparam int          CTRL_LINEAR    = 2;
  localparam int          CTRL_GANTRY    = 3;
  localparam int          ENABLE_US      = 10;
  localparam int          CLK_MHZ        = 100;
  localparam int          ENABLE_CYC     = ENABLE_US * CLK_MHZ;
  localparam int          NUM_SLOTS      = 5;

  typedef struct packed {
    logic alarm;
    logic warn;
    logic drive_ready;
    logic servo_ready;
    logic motion;
    logic brake_release;
    logic cmd_accept;
    logic overspeed;
  } sso_status_t;

  typedef enum logic [1:0] {
    SV_OFF     = 2'b00,
    SV_ENABLE  = 2'b01,
    SV_BRAKE   = 2'b10,
    SV_ON      = 2'b11
  } sso_state_t;
endpackage

// File: verilog/sso_top.sv
// Purpose: Status outputs, servo-on gating and speed supervision of a servo drive.
// Assumes: Speed and condition inputs come from logic on clk_sys_i.
// Notes:   Slots are general outputs; only the caution status is routed here.
// Notes on behaviour
// - Alarm output high while any alarm is active, low in normal state.
// - Caution output high while a quantity nears its critical value.
// - One allocation digit picks the general slot carrying caution status.
// - Drive-ready needs no alarm, encoder, params, mains, partner, no torque-off.
// - Gantry partner readiness counts only when gantry communication is on.
// - Servo-on ignored while drive-ready low; acted on only after it rises.
// - Accepted servo-on runs enable then brake release; servo-ready once enabled.
// - Commands disregarded while servo-ready low; controller waits for it.
// - Rotary motor: motion detect follows speed against rotary threshold.
// - Linear motor: motion detect follows speed against linear threshold.
// - Rotary threshold 1 to 10000 rpm, default 20, effective at once.
// - Linear threshold 1 to 10000 mm/s, default 20, effective at once.
// - Overspeed alarm when speed exceeds the motor-type maximum limit.
// - Rotary limit 0 to 65535 rpm, default 10000, effective after power-on; here writes never apply, since reset restores the default.
// - Linear limit 0 to 100 in 100 mm/s, default 50, after power-on; here writes never apply, since reset restores the default.
// - Control-mode digit 0 selects velocity mode, applied after power-on; here mode writes never apply, so velocity mode always holds.
// - Each slot has polarity; 1 makes it active when condition fails.
// - Allocation 0 leaves status unassigned; 1 to 5 pick slots one to five.
`timescale 1ns/1ps
module sso_top #(
  parameter int ENABLE_CYCLES = sso_pkg::ENABLE_CYC
) (
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          resetn_i,
  // Avalon-MM slave
  input  wire logic [7:0]                    avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [31:0]                   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic      [31:0]                   avs_readdata_o,
  output logic                               avs_waitrequest_o,
  // Drive conditions
  input  wire logic                          alarm_active_i,
  input  wire logic                          warn_active_i,
  input  wire logic                          encoder_ready_i,
  input  wire logic                          params_ready_i,
  input  wire logic                          mains_ready_i,
  input  wire logic                          partner_ready_i,
  input  wire logic                          safe_torque_off_i,
  input  wire logic                          motor_enabled_i,
  input  wire logic                          brake_done_i,
  input  wire logic [15:0]                   speed_i,
  input  wire logic                          cmd_valid_i,
  // Status outputs
  output sso_pkg::sso_status_t               status_o,
  output logic                               motor_enable_o,
  output logic                               cmd_valid_o,
  output logic                               velocity_mode_o,
  output logic      [sso_pkg::NUM_SLOTS-1:0] general_output_slots_o
);
  import sso_pkg::*;

  // The enable-bound check below only covers sequences of at most 1000 cycles,
  // so longer enable timeouts are refused here rather than left unchecked.
  if (ENABLE_CYCLES < 1 || ENABLE_CYCLES > 1000) begin : g_bad_enable
    $error("ENABLE_CYCLES must lie between 1 and 1000");
  end

  // ==========================================================================
  // Register file
  logic [15:0] rot_thr_ff, nxt_rot_thr, lin_thr_ff, nxt_lin_thr;
  logic [15:0] rot_lim_ff, nxt_rot_lim, lin_lim_ff, nxt_lin_lim;
  logic [15:0] mode_ff, nxt_mode, alloc_ff, nxt_alloc;
  // Slot five keeps its polarity at bit 16, above the 16-bit data of the others.
  logic [19:0] pol_ff, nxt_pol;
  logic [15:0] ctrl_ff, nxt_ctrl;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        wait_ff, nxt_wait;
  logic [15:0] wdat;
  sso_status_t st_ff, nxt_st;

  assign wdat = avs_writedata_i[15:0];

  // Each access is answered one cycle after it is presented.
  always_comb begin
    nxt_rot_thr = rot_thr_ff;
    nxt_lin_thr = lin_thr_ff;
    nxt_rot_lim = rot_lim_ff;
    nxt_lin_lim = lin_lim_ff;
    nxt_mode    = mode_ff;
    nxt_alloc   = alloc_ff;
    nxt_pol     = pol_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_rdata   = rdata_ff;
    nxt_wait    = 1'b1;
    if ((avs_read_i || avs_write_i) && wait_ff) begin
      nxt_wait = 1'b0;
    end
    if (avs_write_i && wait_ff && (&avs_byteenable_i[1:0])) begin
      case (avs_address_i)
        OFS_ROT_THR: begin
          // Out-of-range threshold writes are dropped.
          if (wdat >= THR_MIN && wdat <= THR_MAX) nxt_rot_thr = wdat;
        end
        OFS_LIN_THR: begin
          if (wdat >= THR_MIN && wdat <= THR_MAX) nxt_lin_thr = wdat;
        end
        OFS_ROT_LIM:   nxt_rot_lim = wdat;
        OFS_LIN_LIM: begin
          if (wdat <= LIN_LIM_MAX) nxt_lin_lim = wdat;
        end
        OFS_MODE:      nxt_mode  = wdat;
        OFS_OUT_ALLOC: nxt_alloc = wdat;
        OFS_OUT_POL:   nxt_pol   = avs_writedata_i[19:0];
        OFS_CTRL:      nxt_ctrl  = wdat;
        default:       nxt_ctrl  = ctrl_ff;
      endcase
    end
    if (avs_read_i && wait_ff) begin
      case (avs_address_i)
        OFS_ROT_THR:   nxt_rdata = {16'h0000, rot_thr_ff};
        OFS_LIN_THR:   nxt_rdata = {16'h0000, lin_thr_ff};
        OFS_ROT_LIM:   nxt_rdata = {16'h0000, rot_lim_ff};
        OFS_LIN_LIM:   nxt_rdata = {16'h0000, lin_lim_ff};
        OFS_MODE:      nxt_rdata = {16'h0000, mode_ff};
        OFS_OUT_ALLOC: nxt_rdata = {16'h0000, alloc_ff};
        OFS_OUT_POL:   nxt_rdata = {12'h000, pol_ff};
        OFS_CTRL:      nxt_rdata = {16'h0000, ctrl_ff};
        OFS_SPEED:     nxt_rdata = {16'h0000, speed_i};
        OFS_STATUS:    nxt_rdata = {24'h00_0000, st_ff};
        default:       nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rot_thr_ff <= RST_ROT_THR;
      lin_thr_ff <= RST_LIN_THR;
      rot_lim_ff <= RST_ROT_LIM;
      lin_lim_ff <= RST_LIN_LIM;
      mode_ff    <= RST_MODE;
      alloc_ff   <= RST_OUT_ALLOC;
      pol_ff     <= 20'(RST_OUT_POL);
      ctrl_ff    <= RST_CTRL;
      rdata_ff   <= 32'h0000_0000;
      wait_ff    <= 1'b1;
    end else begin
      rot_thr_ff <= nxt_rot_thr;
      lin_thr_ff <= nxt_lin_thr;
      rot_lim_ff <= nxt_rot_lim;
      lin_lim_ff <= nxt_lin_lim;
      mode_ff    <= nxt_mode;
      alloc_ff   <= nxt_alloc;
      pol_ff     <= nxt_pol;
      ctrl_ff    <= nxt_ctrl;
      rdata_ff   <= nxt_rdata;
      wait_ff    <= nxt_wait;
    end
  end

  assign avs_readdata_o    = rdata_ff;
  assign avs_waitrequest_o = wait_ff;

  // ==========================================================================
  // Power-on settings: limits and mode latch once after reset release.
  // Software changes never take hold, since reset also restores the register defaults.
  logic [15:0] act_rot_lim_ff, nxt_act_rot_lim, act_lin_lim_ff, nxt_act_lin_lim;
  logic        vel_ff, nxt_vel, latched_ff, nxt_latched;

  always_comb begin
    nxt_act_rot_lim = act_rot_lim_ff;
    nxt_act_lin_lim = act_lin_lim_ff;
    nxt_vel         = vel_ff;
    nxt_latched     = 1'b1;
    if (!latched_ff) begin
      nxt_act_rot_lim = rot_lim_ff;
      nxt_act_lin_lim = lin_lim_ff;
      nxt_vel = (mode_ff[MODE_DIG_LSB +: 4] == MODE_VELOCITY);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      act_rot_lim_ff <= RST_ROT_LIM;
      act_lin_lim_ff <= RST_LIN_LIM;
      vel_ff         <= 1'b1;
      latched_ff     <= 1'b0;
    end else begin
      act_rot_lim_ff <= nxt_act_rot_lim;
      act_lin_lim_ff <= nxt_act_lin_lim;
      vel_ff         <= nxt_vel;
      latched_ff     <= nxt_latched;
    end
  end

  assign velocity_mode_o = vel_ff;

  // ==========================================================================
  // Status evaluation and servo-on sequence
  logic        linear, gantry, son, drdy_c, over_c, motion_c;
  logic [15:0] thr;
  logic [31:0] lin_lim_mms;
  sso_state_t  sv_ff, nxt_sv;
  logic [31:0] cnt_ff, nxt_cnt;
  logic        motor_en_ff, nxt_motor_en, cmd_ff, nxt_cmd;

  assign linear      = ctrl_ff[CTRL_LINEAR];
  assign gantry      = ctrl_ff[CTRL_GANTRY];
  assign son         = ctrl_ff[CTRL_SON];
  assign lin_lim_mms = 32'(act_lin_lim_ff) * 32'(LIN_LIM_SCALE);
  assign thr         = linear ? lin_thr_ff : rot_thr_ff;
  assign drdy_c      = !alarm_active_i && encoder_ready_i && params_ready_i &&
                       mains_ready_i && (partner_ready_i || !gantry) &&
                       !safe_torque_off_i;
  assign over_c      = linear ? ({16'h0000, speed_i} > lin_lim_mms) :
                                (speed_i > act_rot_lim_ff);

  always_comb begin
    motion_c = st_ff.motion;
    if (speed_i > thr) motion_c = 1'b1;
    else if (speed_i < thr) motion_c = 1'b0;
  end

  always_comb begin
    nxt_sv       = sv_ff;
    nxt_cnt      = cnt_ff;
    nxt_motor_en = motor_en_ff;
    case (sv_ff)
      SV_OFF: begin
        nxt_motor_en = 1'b0;
        if (son && drdy_c && st_ff.drive_ready) begin
          nxt_sv       = SV_ENABLE;
          nxt_cnt      = 32'h0000_0000;
          nxt_motor_en = 1'b1;
        end
      end
      SV_ENABLE: begin
        nxt_cnt = cnt_ff + 32'h0000_0001;
        if (motor_enabled_i || cnt_ff >= 32'(ENABLE_CYCLES - 1)) nxt_sv = SV_BRAKE;
      end
      SV_BRAKE: begin
        if (brake_done_i) nxt_sv = SV_ON;
      end
      SV_ON: nxt_sv = SV_ON;
      default: nxt_sv = SV_OFF;
    endcase
    if (sv_ff != SV_OFF && (!son || !drdy_c || over_c)) begin
      nxt_sv       = SV_OFF;
      nxt_motor_en = 1'b0;
    end
  end

  always_comb begin
    nxt_st               = st_ff;
    nxt_st.overspeed     = over_c;
    nxt_st.alarm         = alarm_active_i || over_c;
    nxt_st.warn          = warn_active_i;
    nxt_st.drive_ready   = drdy_c && !over_c;
    nxt_st.motion        = motion_c;
    nxt_st.servo_ready   = (nxt_sv == SV_BRAKE || nxt_sv == SV_ON);
    nxt_st.brake_release = (nxt_sv == SV_ON);
    nxt_st.cmd_accept    = nxt_st.servo_ready;
    nxt_cmd              = cmd_valid_i && st_ff.servo_ready && nxt_st.servo_ready;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      st_ff       <= '0;
      sv_ff       <= SV_OFF;
      cnt_ff      <= 32'h0000_0000;
      motor_en_ff <= 1'b0;
      cmd_ff      <= 1'b0;
    end else begin
      st_ff       <= nxt_st;
      sv_ff       <= nxt_sv;
      cnt_ff      <= nxt_cnt;
      motor_en_ff <= nxt_motor_en;
      cmd_ff      <= nxt_cmd;
    end
  end

  assign status_o       = st_ff;
  assign motor_enable_o = motor_en_ff;
  assign cmd_valid_o    = cmd_ff;

  // ==========================================================================
  // General output slots
  logic [NUM_SLOTS-1:0] slot_ff, nxt_slot;
  logic [3:0]           warn_sel;
  assign warn_sel = alloc_ff[WARN_DIG_LSB +: 4];

  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    always_comb begin
      // Selection value 0 and values above five reach no slot.
      nxt_slot[g] = (warn_sel == 4'(g + 1)) ? nxt_st.warn : 1'b0;
      nxt_slot[g] = nxt_slot[g] ^ pol_ff[g * 4];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) slot_ff <= '0;
    else slot_ff <= nxt_slot;
  end

  assign general_output_slots_o = slot_ff;

  // ==========================================================================
  // Checks
  a_alarm_follows: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    alarm_active_i |=> status_o.alarm) else $error("alarm output missed");
  a_warn_follows: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    warn_active_i |=> status_o.warn) else $error("caution output missed");
  a_drdy_stof: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    safe_torque_off_i |=> !status_o.drive_ready) else $error("ready under torque off");
  a_son_gated: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (sv_ff == SV_OFF && !st_ff.drive_ready) |=> sv_ff == SV_OFF)
    else $error("servo-on taken while not ready");
  a_cmd_gated: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !status_o.servo_ready |=> !cmd_valid_o) else $error("command passed while not ready");
  a_motion_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (speed_i == thr) |=> $stable(status_o.motion)) else $error("motion chattered");
  a_motion_above: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (speed_i > thr) |=> status_o.motion) else $error("motion not detected");
  a_motion_below: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (speed_i < thr) |=> !status_o.motion) else $error("motion not cleared");
  // A standing motor cannot exceed any limit, so only the listed conditions matter.
  a_gantry_ignored: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (!gantry && !alarm_active_i && encoder_ready_i && params_ready_i && mains_ready_i &&
     !safe_torque_off_i && speed_i == 16'h0000) |=> status_o.drive_ready)
    else $error("partner readiness not ignored");
  a_overspeed_rot: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (!linear && speed_i > act_rot_lim_ff) |=> status_o.alarm)
    else $error("rotary overspeed missed");
  // Once latched, the mode must hold until the next reset.
  a_mode_fixed: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    latched_ff |=> $stable(velocity_mode_o)) else $error("mode changed after power-on");
  a_sready_drop: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    alarm_active_i |=> !status_o.servo_ready) else $error("servo-ready held on alarm");
  a_enable_bound: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(motor_enable_o) |-> ##[1:1000] (status_o.servo_ready || !motor_enable_o))
    else $error("enable sequence stalled");
endmodule

// File: dv/sso_ctrl_model.sv
// Purpose: Motion controller model that faces the drive status outputs.
// Assumes: Same clock as the drive.
// Notes:   Rogue mode skips the servo-ready wait so the bench can test gating.
`timescale 1ns/1ps
module sso_ctrl_model (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Drive status and bench requests
  input  wire logic        servo_ready_i,
  input  wire logic        velocity_mode_i,
  input  wire logic        cmd_req_i,
  input  wire logic        rogue_i,
  input  wire logic [15:0] speed_req_i,
  // Controller outputs
  output logic             cmd_valid_o,
  output logic      [15:0] speed_o
);
  // ==========================================================================
  // Command and speed drive
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cmd_valid_o <= 1'b0;
      speed_o     <= 16'h0000;
    end else begin
      cmd_valid_o <= cmd_req_i & (servo_ready_i | rogue_i);
      speed_o     <= velocity_mode_i ? speed_req_i : 16'h0000;
    end
  end
endmodule

// File: dv/sso_top_test.sv
// Purpose: Self-checking bench for the servo status output block.
// Assumes: Enable timeout shortened to 4 cycles.
// Notes:   Status is sampled a few cycles after each input change.
`timescale 1ns/1ps
module sso_top_test;
  import sso_pkg::*;
  // ==========================================================================
  // Signals
  logic        clk_sys_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic [7:0]  adr       = 8'h00;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wd        = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        waitreq;
  logic        alarm = 1'b0, warn = 1'b0, enc = 1'b1, par = 1'b1, mains = 1'b1;
  logic        prt = 1'b1, safe_torque_off = 1'b0, men = 1'b0, bdone = 1'b0;
  logic        creq = 1'b0, rogue = 1'b0;
  logic [15:0] sreq = 16'h0000;
  logic [15:0] speed;
  logic        cmdv, men_o, cmd_o, vmode;
  logic [4:0]  slots;
  logic [5:0]  c;
  logic        g;
  logic [31:0] pol;
  sso_status_t st;
  int          err_count = 0;
  int          compares  = 0;
  int          thr;
  logic [7:0]  ofs [4] = '{OFS_ROT_THR, OFS_LIN_THR, OFS_ROT_LIM, OFS_LIN_LIM};
  logic [15:0] dfl [4] = '{RST_ROT_THR, RST_LIN_THR, RST_ROT_LIM, RST_LIN_LIM};

  always #5 clk_sys_i = ~clk_sys_i;

  sso_top #(.ENABLE_CYCLES(4)) i_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq), .alarm_active_i(alarm),
    .warn_active_i(warn), .encoder_ready_i(enc), .params_ready_i(par),
    .mains_ready_i(mains), .partner_ready_i(prt), .safe_torque_off_i(safe_torque_off),
    .motor_enabled_i(men), .brake_done_i(bdone), .speed_i(speed), .cmd_valid_i(cmdv),
    .status_o(st), .motor_enable_o(men_o), .cmd_valid_o(cmd_o),
    .velocity_mode_o(vmode), .general_output_slots_o(slots));

  sso_ctrl_model i_ctrl (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .servo_ready_i(st.servo_ready),
    .velocity_mode_i(vmode), .cmd_req_i(creq), .rogue_i(rogue), .speed_req_i(sreq),
    .cmd_valid_o(cmdv), .speed_o(speed));

  // ==========================================================================
  // Helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    compares++;
    if (v !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, v);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then releases it.
  // No cycle limit here: the watchdog ends a run whose answer never comes.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    adr <= a;
    wr  <= w;
    rd  <= !w;
    wd  <= d;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (waitreq !== 1'b0);
    chk("bus latency", 32'h0000_0002, 32'(n));
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic sp(input int s, input logic e);
    sreq <= 16'(s);
    wt(5);
    chk("motion", 32'(e), 32'(st.motion));
  endtask

  function automatic logic [4:0] exp_slots(input int dig, input logic [31:0] p, input logic w);
    logic [4:0] s;
    for (int i = 0; i < 5; i++) s[i] = ((dig == i + 1) & w) ^ p[4*i];
    return s;
  endfunction

  task automatic results();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    wt(20000);
    err_count++;
    results();
  end

  // ==========================================================================
  // Scenarios
  initial begin
    void'($urandom(34003));
    wt(5);
    resetn_i <= 1'b1;
    wt(2);
    chk("velocity mode", 32'h1, 32'(vmode));
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, ofs[i], 32'h0);
      chk("reset value", 32'(dfl[i]), q);
    end
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, q);
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, OFS_CTRL, m ? 32'h4 : 32'h0);
      for (int k = 0; k < 3; k++) begin
        thr = (k == 0) ? 2 : $urandom_range(m ? 4000 : 9000, 2);
        bus(1'b1, m ? OFS_LIN_THR : OFS_ROT_THR, 32'(thr));
        bus(1'b1, m ? OFS_LIN_THR : OFS_ROT_THR, 32'h0);
        bus(1'b0, m ? OFS_LIN_THR : OFS_ROT_THR, 32'h0);
        chk("threshold", 32'(thr), q);
        sp(thr + 1, 1'b1);
        sp(thr, 1'b1);
        sp(thr - 1, 1'b0);
        sp(thr, 1'b0);
      end
    end
    sp(5001, 1'b1);
    chk("linear overspeed", 32'h1, 32'(st.overspeed));
    sp(5000, 1'b1);
    chk("linear limit", 32'h0, 32'(st.overspeed));
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_ROT_LIM, 32'h0064);
    sp(10001, 1'b1);
    chk("overspeed", 32'h1, 32'(st.overspeed));
    chk("alarm", 32'h1, 32'(st.alarm));
    sp(10000, 1'b1);
    chk("limit after power-on", 32'h0, 32'(st.overspeed));
    bus(1'b1, OFS_MODE, 32'h0000_0010);
    sp(0, 1'b0);
    chk("velocity mode", 32'h1, 32'(vmode));
    for (int i = 0; i < 24; i++) begin
      c = 6'($urandom);
      g = 1'($urandom);
      bus(1'b1, OFS_CTRL, {28'h0, g, 3'b000});
      {alarm, enc, par, mains, prt, safe_torque_off} <= c;
      wt(4);
      chk("drive ready", 32'(!c[5] & c[4] & c[3] & c[2] & (c[1] | !g) & !c[0]),
          32'(st.drive_ready));
      chk("alarm", 32'(c[5]), 32'(st.alarm));
    end
    for (int d = 0; d < 6; d++) begin
      pol = $urandom & 32'h0001_1111;
      warn <= 1'($urandom);
      bus(1'b1, OFS_OUT_ALLOC, 32'(d << 4));
      bus(1'b1, OFS_OUT_POL, pol);
      wt(4);
      chk("caution", 32'(warn), 32'(st.warn));
      chk("slots", 32'(exp_slots(d, pol, warn)), 32'(slots));
    end
    bus(1'b1, OFS_CTRL, 32'h0);
    {alarm, enc, par, mains, prt, safe_torque_off} <= 6'b001110;
    bus(1'b1, OFS_CTRL, 32'h1);
    creq  <= 1'b1;
    rogue <= 1'b1;
    wt(4);
    chk("ignored servo-on", 32'h0, 32'(men_o));
    chk("gated command", 32'h0, 32'(cmd_o));
    rogue <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0);
    enc <= 1'b1;
    wt(3);
    bus(1'b1, OFS_CTRL, 32'h1);
    wt(2);
    chk("motor enable", 32'h1, 32'(men_o));
    men <= 1'b1;
    wt(4);
    chk("servo ready", 32'h1, 32'(st.servo_ready));
    chk("command", 32'h1, 32'(cmd_o));
    chk("command accept", 32'h1, 32'(st.cmd_accept));
    bdone <= 1'b1;
    wt(3);
    chk("brake release", 32'h1, 32'(st.brake_release));
    alarm <= 1'b1;
    wt(3);
    chk("servo ready drop", 32'h0, 32'(st.servo_ready));
    chk("motor enable drop", 32'h0, 32'(men_o));
    results();
  end
endmodule
